//--- pkg/scd_regs.svh
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SCD_ADDR_W 12
`define SCD_OFF_SYSREF_CTRL 12'h10a
`define SCD_OFF_DELAY_MODE 12'h110
`define SCD_OFF_SUPER_FINE 12'h111
`define SCD_OFF_FINE 12'h112
`define SCD_OFF_DETECT_THR 12'h11a
`define SCD_OFF_CLK_STATUS 12'h11b
`define SCD_OFF_STAB_ONE 12'h11c

// ****************************************************************
// Field positions
// ****************************************************************
`define SCD_AUTOPHASE_BIT 7
`define SCD_NEG_SKEW_HI 3
`define SCD_NEG_SKEW_LO 2
`define SCD_POS_SKEW_HI 1
`define SCD_POS_SKEW_LO 0
`define SCD_MODE_HI 2
`define SCD_MODE_LO 0
`define SCD_THR_HI 4
`define SCD_THR_LO 3
`define SCD_STAB_POWER_BIT 0
`define SCD_STAB_ENABLE_BIT 1

// ****************************************************************
// Reset values
// ****************************************************************
`define SCD_RST_SYSREF_CTRL 8'h00
`define SCD_RST_DELAY_MODE 8'h00
`define SCD_RST_SUPER_FINE 8'h00
`define SCD_RST_FINE 8'hc0
`define SCD_RST_DETECT_THR 8'h09
`define SCD_RST_STAB_ONE 8'h08

// ****************************************************************
// Step limits
// ****************************************************************
`define SCD_FINE_LIMITED_MAX 8'h10
`define SCD_FINE_FULL_MAX 8'hc0
`define SCD_SUPER_FINE_MAX 8'h80

`endif

//--- pkg/scd_pkg.sv
package scd_pkg;
  // Clock delay mode codes
  typedef enum logic [2:0] {
    SCD_MODE_NONE = 3'h0,
    SCD_MODE_RSVD1 = 3'h1,
    SCD_MODE_FINE_LIM = 3'h2,
    SCD_MODE_FINE_LOWJIT = 3'h3,
    SCD_MODE_FINE_FULL = 3'h4,
    SCD_MODE_FINE_FULL_ALIAS = 3'h5,
    SCD_MODE_FINE_SUPER = 3'h6,
    SCD_MODE_RSVD7 = 3'h7
  } scd_delay_mode_t;

  // Register byte type
  typedef logic [7:0] scd_byte_t;
endpackage : scd_pkg

//--- hdl/scd_sample_clock_delay_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "scd_regs.svh"

module scd_sample_clock_delay_control (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [`SCD_ADDR_W-1:0] regAddr, // Register index from serial port
  input wire logic [7:0] regWdata,
  input wire logic regWrite, // One-cycle write strobe
  input wire logic regRead, // One-cycle read strobe
  output logic [7:0] regRdata,
  output logic regRdataValid,
  input wire logic inputClockLocked, // Asynchronous detector level
  output logic autophaseEnable,
  output logic [1:0] positiveSkewHalfClocks,
  output logic [1:0] negativeSkewHalfClocks,
  output logic fineDelayEnable,
  output logic lowJitterMode,
  output logic [7:0] fineDelayApplied,
  output logic superFineEnable,
  output logic [7:0] superFineApplied,
  output logic [1:0] detectThreshold,
  output logic stabilizerPowerUp,
  output logic stabilizerEnable
);
  import scd_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Saturate a step count at the valid maximum for the mode
  function automatic scd_byte_t clampSteps(input scd_byte_t steps, input scd_byte_t maxSteps);
    clampSteps = (steps > maxSteps) ? maxSteps : steps;
  endfunction

  // ****************************************************************
  // Register storage
  // ****************************************************************
  scd_byte_t sysrefCtrl; // Autophase and skew windows
  scd_byte_t delayModeReg; // Mode field in low bits
  scd_byte_t superFineReg; // Super fine step count
  scd_byte_t fineReg; // Fine step count
  scd_byte_t detectThrReg; // Threshold plus writable reserved bits
  scd_byte_t stabOneReg; // Stabilizer power and enable
  logic lockSync1; // First synchroniser stage, read only by stage two
  logic lockSync2; // Synchronised detector level
  scd_delay_mode_t modeSel; // Decoded mode field
  scd_byte_t next_rdata; // Read mux result

  // Write decode for the SYSREF control byte; reserved [6:4] not stored
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sysrefCtrl <= `SCD_RST_SYSREF_CTRL;
    end else if (regWrite && regAddr == `SCD_OFF_SYSREF_CTRL) begin
      sysrefCtrl <= regWdata & 8'h8f;
    end
  end

  // Delay mode register; bits [7:3] read only zero
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      delayModeReg <= `SCD_RST_DELAY_MODE;
    end else if (regWrite && regAddr == `SCD_OFF_DELAY_MODE) begin
      delayModeReg <= regWdata & 8'h07;
    end
  end

  // Super fine and fine step counts, stored as written
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      superFineReg <= `SCD_RST_SUPER_FINE;
      fineReg <= `SCD_RST_FINE;
    end else if (regWrite) begin
      if (regAddr == `SCD_OFF_SUPER_FINE) begin
        superFineReg <= regWdata;
      end
      if (regAddr == `SCD_OFF_FINE) begin
        fineReg <= regWdata;
      end
    end
  end

  // Detection threshold; all bits writable
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      detectThrReg <= `SCD_RST_DETECT_THR;
    end else if (regWrite && regAddr == `SCD_OFF_DETECT_THR) begin
      detectThrReg <= regWdata;
    end
  end

  // Stabilizer control; bit 2 not implemented and reads zero
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stabOneReg <= `SCD_RST_STAB_ONE;
    end else if (regWrite && regAddr == `SCD_OFF_STAB_ONE) begin
      stabOneReg <= regWdata & 8'hfb;
    end
  end

  // ****************************************************************
  // Clock detector crossing
  // ****************************************************************

  // Two flops; the level tracks the detector with no sticky state
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lockSync1 <= 1'b0;
      lockSync2 <= 1'b0;
    end else begin
      lockSync1 <= inputClockLocked;
      lockSync2 <= lockSync1;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************

  // Unmapped addresses read zero
  always_comb begin
    case (regAddr)
      `SCD_OFF_SYSREF_CTRL: next_rdata = sysrefCtrl;
      `SCD_OFF_DELAY_MODE: next_rdata = delayModeReg;
      `SCD_OFF_SUPER_FINE: next_rdata = superFineReg;
      `SCD_OFF_FINE: next_rdata = fineReg;
      `SCD_OFF_DETECT_THR: next_rdata = detectThrReg;
      `SCD_OFF_CLK_STATUS: next_rdata = {7'h00, lockSync2};
      `SCD_OFF_STAB_ONE: next_rdata = stabOneReg;
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data registered, valid one cycle after the strobe
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
      regRdataValid <= 1'b0;
    end else begin
      regRdataValid <= regRead;
      if (regRead) begin
        regRdata <= next_rdata;
      end
    end
  end

  // ****************************************************************
  // Alignment skew windows
  // ****************************************************************

  // Windows forced to zero while autophase is off, so the pulse
  // cannot move the divider phase
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      autophaseEnable <= 1'b0;
      positiveSkewHalfClocks <= 2'h0;
      negativeSkewHalfClocks <= 2'h0;
    end else begin
      autophaseEnable <= sysrefCtrl[`SCD_AUTOPHASE_BIT];
      if (sysrefCtrl[`SCD_AUTOPHASE_BIT]) begin
        // Code counts half clocks; 00 means exact capture
        positiveSkewHalfClocks <= sysrefCtrl[`SCD_POS_SKEW_HI:`SCD_POS_SKEW_LO];
        negativeSkewHalfClocks <= sysrefCtrl[`SCD_NEG_SKEW_HI:`SCD_NEG_SKEW_LO];
      end else begin
        positiveSkewHalfClocks <= 2'h0;
        negativeSkewHalfClocks <= 2'h0;
      end
    end
  end

  // ****************************************************************
  // Delay application
  // ****************************************************************
  assign modeSel = scd_delay_mode_t'(delayModeReg[`SCD_MODE_HI:`SCD_MODE_LO]);

  // Out-of-range steps saturate rather than wrap, so a bad write
  // gives the nearest valid delay instead of a tiny one
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fineDelayEnable <= 1'b0;
      lowJitterMode <= 1'b0;
      fineDelayApplied <= 8'h00;
      superFineEnable <= 1'b0;
      superFineApplied <= 8'h00;
    end else begin
      case (modeSel)
        SCD_MODE_FINE_LIM: begin
          fineDelayEnable <= 1'b1;
          lowJitterMode <= 1'b0;
          fineDelayApplied <= clampSteps(fineReg, `SCD_FINE_LIMITED_MAX);
          superFineEnable <= 1'b0;
          superFineApplied <= 8'h00;
        end
        SCD_MODE_FINE_LOWJIT: begin
          fineDelayEnable <= 1'b1;
          lowJitterMode <= 1'b1;
          fineDelayApplied <= clampSteps(fineReg, `SCD_FINE_LIMITED_MAX);
          superFineEnable <= 1'b0;
          superFineApplied <= 8'h00;
        end
        SCD_MODE_FINE_FULL, SCD_MODE_FINE_FULL_ALIAS: begin
          fineDelayEnable <= 1'b1;
          lowJitterMode <= 1'b0;
          fineDelayApplied <= clampSteps(fineReg, `SCD_FINE_FULL_MAX);
          superFineEnable <= 1'b0;
          superFineApplied <= 8'h00;
        end
        SCD_MODE_FINE_SUPER: begin
          fineDelayEnable <= 1'b1;
          lowJitterMode <= 1'b0;
          fineDelayApplied <= clampSteps(fineReg, `SCD_FINE_FULL_MAX);
          superFineEnable <= 1'b1;
          superFineApplied <= clampSteps(superFineReg, `SCD_SUPER_FINE_MAX);
        end
        default: begin
          // 000 and reserved 001/111: no sample clock delay
          fineDelayEnable <= 1'b0;
          lowJitterMode <= 1'b0;
          fineDelayApplied <= 8'h00;
          superFineEnable <= 1'b0;
          superFineApplied <= 8'h00;
        end
      endcase
    end
  end

  // ****************************************************************
  // Detection threshold and stabilizer
  // ****************************************************************

  // Enable is gated by power so a misordered write cannot run an
  // unpowered stabilizer
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      detectThreshold <= 2'h1;
      stabilizerPowerUp <= 1'b0;
      stabilizerEnable <= 1'b0;
    end else begin
      detectThreshold <= detectThrReg[`SCD_THR_HI:`SCD_THR_LO];
      stabilizerPowerUp <= stabOneReg[`SCD_STAB_POWER_BIT];
      stabilizerEnable <= stabOneReg[`SCD_STAB_ENABLE_BIT]
        & stabOneReg[`SCD_STAB_POWER_BIT];
    end
  end

endmodule // scd_sample_clock_delay_control

`default_nettype wire

//--- test/scd_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "scd_regs.svh"
// ****
// Port checker
// ****
module scd_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [`SCD_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic regRdataValid,
  input wire logic autophaseEnable,
  input wire logic [1:0] positiveSkewHalfClocks,
  input wire logic fineDelayEnable,
  input wire logic lowJitterMode,
  input wire logic [7:0] fineDelayApplied,
  input wire logic superFineEnable,
  input wire logic [7:0] superFineApplied,
  input wire logic [1:0] detectThreshold,
  input wire logic stabilizerPowerUp,
  input wire logic stabilizerEnable
);
  // One domain, so one clock and one reset for all
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_RD_LAT: assert property (regRead |=> regRdataValid)
    else $error("read not answered");
  AST_NO_SPUR: assert property (!regRead |=> !regRdataValid)
    else $error("spurious read answer");
  AST_FINE_LIM: assert property (
    lowJitterMode |-> fineDelayEnable && fineDelayApplied <= 8'h10)
    else $error("low jitter fine range");
  AST_SKEW: assert property (
    !autophaseEnable |-> positiveSkewHalfClocks == 2'h0)
    else $error("skew without autophase");
  AST_THR: assert property (
    regWrite && regAddr == 12'h11a |=> ##1 detectThreshold == $past(regWdata[4:3], 2))
    else $error("threshold not applied");
  AST_MODE6: assert property (
    regWrite && regAddr == 12'h110 && regWdata[2:0] == 3'h6 |=> ##1 superFineEnable)
    else $error("super fine not enabled");
  AST_MODE0: assert property (
    regWrite && regAddr == 12'h110 && regWdata[2:0] == 3'h0
    |=> ##1 !fineDelayEnable && fineDelayApplied == 8'h00)
    else $error("delay in mode zero");
  AST_STAB: assert property (stabilizerEnable |-> stabilizerPowerUp)
    else $error("stabilizer on while down");
  AST_SF: assert property (
    superFineApplied <= (superFineEnable ? 8'h80 : 8'h00))
    else $error("super fine out of range");
endmodule // scd_chk
bind scd_sample_clock_delay_control scd_chk u_chk (.sys_clk, .sys_rst, .regAddr, .regWdata,
  .regWrite, .regRead, .regRdataValid, .autophaseEnable, .positiveSkewHalfClocks,
  .fineDelayEnable, .lowJitterMode, .fineDelayApplied, .superFineEnable, .superFineApplied,
  .detectThreshold, .stabilizerPowerUp, .stabilizerEnable);
`default_nettype wire

//--- test/scd_sample_clock_delay_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "scd_regs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin nFail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module scd_sample_clock_delay_control_tb;
  import scd_pkg::*;
  logic sys_clk = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, inputClockLocked = 1'b0;
  logic [`SCD_ADDR_W-1:0] regAddr = '0;
  scd_byte_t regWdata = 8'h00, regRdata, fineDelayApplied, superFineApplied, f, s, ef, es;
  logic regRdataValid, autophaseEnable, fineDelayEnable, lowJitterMode, superFineEnable;
  logic stabilizerPowerUp, stabilizerEnable;
  logic [1:0] positiveSkewHalfClocks, negativeSkewHalfClocks, detectThreshold;
  scd_byte_t expQ[$]; // Expected read data, oldest first
  int nFail = 0, checked = 0;
  logic [11:0] ra[7] = '{12'h110, 12'h111, 12'h112, 12'h11a, 12'h11b, 12'h11c, 12'h1ff};
  scd_byte_t re[7] = '{8'h00, 8'h00, 8'hc0, 8'h09, 8'h00, 8'h08, 8'h00};
  scd_sample_clock_delay_control u_dut (.sys_clk, .sys_rst, .regAddr, .regWdata, .regWrite,
    .regRead, .regRdata, .regRdataValid, .inputClockLocked, .autophaseEnable,
    .positiveSkewHalfClocks, .negativeSkewHalfClocks, .fineDelayEnable, .lowJitterMode,
    .fineDelayApplied, .superFineEnable, .superFineApplied, .detectThreshold,
    .stabilizerPowerUp, .stabilizerEnable);
  // ****
  // Clock and bus tasks
  // ****
  initial forever #25 sys_clk = ~sys_clk;
  task automatic tick(); @(posedge sys_clk); #1; endtask
  // Strobes stay up between back-to-back cycles, so no double assignment
  task automatic wr(input logic [11:0] a, input scd_byte_t d);
    regAddr = a; regWdata = d; regWrite = 1'b1; regRead = 1'b0; tick();
  endtask
  task automatic rd(input logic [11:0] a, input scd_byte_t e);
    regAddr = a; regRead = 1'b1; regWrite = 1'b0; expQ.push_back(e); tick();
  endtask
  task automatic idle(input int n); regRead = 1'b0; regWrite = 1'b0; repeat (n) tick(); endtask
  task automatic giveVerdict();
    if (nFail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Bounded drain; a leftover note means a lost answer
  task automatic settle(); idle(3); if (expQ.size() != 0) begin nFail++; giveVerdict(); end endtask
  // ****
  // Read monitor
  // ****
  always @(posedge sys_clk) begin : mon
    scd_byte_t e;
    if (regRdataValid === 1'b1) begin
      e = expQ.size() ? expQ.pop_front() : 8'hxx; // Unexpected answer never matches
      `CHK("rdata", e, regRdata)
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    void'($urandom(51591));
    repeat (5) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 7; i++) rd(ra[i], re[i]);
    idle(1);
    `CHK("thr", 2'h1, detectThreshold)
    `CHK("stab", 2'h0, {stabilizerPowerUp, stabilizerEnable})
    // Skew codes with autophase, negative field mirrored, then autophase off
    for (int c = 0; c < 4; c++) begin
      wr(`SCD_OFF_SYSREF_CTRL, 8'h80 | ((3 - c) << 2) | c);
      idle(2);
      `CHK("pskew", c[1:0], positiveSkewHalfClocks)
      `CHK("nskew", 2'(3 - c), negativeSkewHalfClocks)
      `CHK("autoph", 1'b1, autophaseEnable)
    end
    // Reserved bits set too; they must not stick
    wr(`SCD_OFF_SYSREF_CTRL, 8'h7f);
    idle(2);
    `CHK("pskew off", 2'h0, positiveSkewHalfClocks)
    `CHK("nskew off", 2'h0, negativeSkewHalfClocks)
    `CHK("autoph off", 1'b0, autophaseEnable)
    rd(`SCD_OFF_SYSREF_CTRL, 8'h0f);
    // Every mode code with random and boundary step counts
    for (int m = 0; m < 8; m++) begin
      f = $urandom;
      s = $urandom;
      // Mode 2 gets one deliberate misuse to exercise the clamp
      if (m == 2) f = 8'h11;
      if (m == 3) f = 8'($urandom % 17);
      if (m == 4) f = 8'hc0;
      wr(`SCD_OFF_FINE, f);
      wr(`SCD_OFF_SUPER_FINE, s);
      wr(`SCD_OFF_DELAY_MODE, m);
      idle(2);
      ef = (m == 2 || m == 3) ? (f > 16 ? 8'h10 : f) :
        (m inside {4, 5, 6}) ? (f > 192 ? 8'hc0 : f) : 8'h00;
      es = (m == 6) ? (s > 128 ? 8'h80 : s) : 8'h00;
      `CHK("fen", (m inside {2, 3, 4, 5, 6}), fineDelayEnable)
      `CHK("lowjit", (m == 3), lowJitterMode)
      `CHK("fine", ef, fineDelayApplied)
      `CHK("sfen", (m == 6), superFineEnable)
      `CHK("sfine", es, superFineApplied)
      rd(`SCD_OFF_FINE, f);
      rd(`SCD_OFF_SUPER_FINE, s);
      rd(`SCD_OFF_DELAY_MODE, m);
      idle(1);
    end
    wr(`SCD_OFF_DETECT_THR, 8'h18);
    idle(2);
    `CHK("thr", 2'h3, detectThreshold)
    rd(`SCD_OFF_DETECT_THR, 8'h18);
    // Enable before power is held off, then proper order
    wr(`SCD_OFF_STAB_ONE, 8'h0a);
    idle(2);
    `CHK("stab en", 1'b0, stabilizerEnable)
    wr(`SCD_OFF_STAB_ONE, 8'h09);
    wr(`SCD_OFF_STAB_ONE, 8'h0b);
    idle(2);
    `CHK("stab", 2'h3, {stabilizerPowerUp, stabilizerEnable})
    rd(`SCD_OFF_STAB_ONE, 8'h0b);
    // Status follows the detector both ways; writes ignored
    inputClockLocked = 1'b1;
    idle(3);
    rd(`SCD_OFF_CLK_STATUS, 8'h01);
    wr(`SCD_OFF_CLK_STATUS, 8'hff);
    inputClockLocked = 1'b0;
    idle(3);
    rd(`SCD_OFF_CLK_STATUS, 8'h00);
    settle();
    giveVerdict();
  end
endmodule // scd_sample_clock_delay_control_tb
`default_nettype wire
